// File: hw/pfc_top.sv
// Two-channel performance counter unit with an APB register slave.
// Assumes core event inputs synchronous to pclk and a single clock domain.
//
// How it works
// - two channels, each with own select and method
// - method one adds one per event cycle
// - method two adds ratio weight 3 to 24
// - each channel counter is 48 bits wide
// - wrap sets sticky overflow until channel cleared
// - operand miss counts reads, writes or both
// - icache miss includes slow uncached and overrun misses
// - TLB misses counted even when later cancelled
// - fetch counts cacheable-with-cache-on or all fetches
// - branches counted issued or taken, zero displacement excluded
// - subroutine call issues counted separately
// - issue counts one per cycle; dual-issue cycles separate
// - fetch exceptions may add one to three
// - FPU issue adds one even when dual
// - trap, normal interrupt and NMI counted separately
// - break channel A and B matches counted
// - fill and elapsed cycles weighted by method
// - freeze events include RAM, I/O, uncached stalls
// - branch freeze counts one cycle, late slot excepted
// - optional start-to-end PC range gates counting
// - clear zeroes counter, and overflow too unless the counter wraps in the clear cycle
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pfc_defines.svh"

module pfc_top
	import pfc_pkg::*;
(
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic [`PFC_ADDR_W-1:0]    paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Core events
	input  wire pfc_events_t               evt,
	input  wire logic [2:0]                clk_ratio,
	input  wire logic                      range_start_hit,
	input  wire logic                      range_end_hit
);

	pfc_state_t                                st;
	pfc_state_t                                next_st;

	logic [`PFC_INC_W-1:0]                     weight;
	logic [`PFC_NUM_CH-1:0]                    clear;
	logic [`PFC_NUM_CH-1:0]                    gate;
	logic [`PFC_NUM_CH-1:0]                    ovf;
	logic [`PFC_NUM_CH-1:0][`PFC_CNT_W-1:0]    count;
	logic [`PFC_NUM_CH-1:0][`PFC_INC_W-1:0]    inc;
	pfc_inc_t [`PFC_NUM_CH-1:0]                dec;

	logic                                      setup;
	logic                                      wr_access;
	logic [`PFC_ADDR_W-1:0]                    word_addr;

	// Turns the selected event into this cycle's raw amount.
	function automatic pfc_inc_t pfc_decode(
		input logic [`PFC_SEL_W-1:0] sel,
		input pfc_events_t           ev
	);
		pfc_inc_t r;
		r = '0;
		case (sel)
			EV_OC_RD: begin
				r.amt = {1'b0, ev.oc_rd_miss};
			end
			EV_OC_WR: begin
				r.amt = {1'b0, ev.oc_wr_miss};
			end
			EV_OC_RW: begin
				r.amt = {1'b0, ev.oc_rd_miss} + {1'b0, ev.oc_wr_miss};
			end
			EV_IC_MISS: begin
				r.amt[0] = ev.ic_miss | ev.ic_uncached_slow | ev.ic_overrun_miss;
			end
			EV_DATA_TLB: begin
				// Raw misses are taken before exception priority cancels them.
				r.amt[0] = ev.unified_tlb_data_miss;
			end
			EV_INST_TLB: begin
				r.amt[0] = ev.unified_tlb_inst_miss | ev.instruction_tlb_miss;
			end
			EV_CACHED_F: begin
				r.amt[0] = ev.fetch_accept & ev.fetch_cacheable & ev.cache_enabled;
			end
			EV_ALL_F: begin
				r.amt[0] = ev.fetch_accept;
			end
			EV_BR_ISSUE: begin
				r.amt[0] = ev.br_issue & ~ev.br_zero_disp;
			end
			EV_BR_TAKEN: begin
				r.amt[0] = ev.br_taken & ~ev.br_zero_disp;
			end
			EV_CALL: begin
				r.amt[0] = ev.call_issue;
			end
			EV_ISSUE: begin
				// A fetch exception replaces the normal one-per-cycle amount.
				if (ev.fetch_exc_cnt != 2'h0)
					r.amt = ev.fetch_exc_cnt;
				else
					r.amt[0] = ev.issue_cycle;
			end
			EV_DUAL: begin
				if (ev.fetch_exc_cnt != 2'h0)
					r.amt = ev.fetch_exc_cnt;
				else
					r.amt[0] = ev.dual_cycle;
			end
			EV_FPU: begin
				r.amt[0] = |ev.fpu_slot;
			end
			EV_TRAP: begin
				r.amt[0] = ev.trap_exec;
			end
			EV_INT: begin
				r.amt[0] = ev.int_accept;
			end
			EV_NMI: begin
				r.amt[0] = ev.nmi_accept;
			end
			EV_BRK_A: begin
				r.amt[0] = ev.brk_a_match;
			end
			EV_BRK_B: begin
				r.amt[0] = ev.brk_b_match;
			end
			EV_IC_FILL: begin
				r.cyc    = 1'b1;
				r.amt[0] = ev.ic_fill;
			end
			EV_OC_FILL: begin
				r.cyc    = 1'b1;
				r.amt[0] = ev.oc_fill;
			end
			EV_ELAPSED: begin
				r.cyc    = 1'b1;
				r.amt[0] = 1'b1;
			end
			EV_IF_FREEZE: begin
				r.cyc    = 1'b1;
				r.amt[0] = ev.if_freeze | ev.if_aux_freeze;
			end
			EV_OP_FREEZE: begin
				r.cyc    = 1'b1;
				r.amt[0] = ev.op_freeze | ev.op_aux_freeze;
			end
			EV_BR_FREEZE: begin
				// Later stall cycles of a target miss belong to the fill event.
				r.cyc    = 1'b1;
				r.amt[0] = ev.br_freeze & ~ev.slot_late;
			end
			default: begin
				r = '0;
			end
		endcase
		return r;
	endfunction

	// The weight tracks the divider each cycle, so ratio changes apply at once.
	pfc_weight u_weight (
		.ratio  (clk_ratio),
		.weight (weight)
	);

	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign word_addr = {paddr[`PFC_ADDR_W-1:2], 2'b00};

	genvar ch;
	generate
		for (ch = 0; ch < `PFC_NUM_CH; ch++) begin : g_ch
			localparam logic [`PFC_ADDR_W-1:0] BASE = `PFC_ADDR_W'(`PFC_CH_STRIDE * ch);

			assign dec[ch] = pfc_decode(st.ctrl[ch].sel, evt);

			// The end-PC cycle itself still counts; the flag drops after it.
			assign gate[ch] = st.ctrl[ch].en &
				(~st.ctrl[ch].range_en | st.in_range[ch] | range_start_hit);

			always_comb begin
				if (!gate[ch])
					inc[ch] = '0;
				else if (dec[ch].cyc && st.ctrl[ch].method && dec[ch].amt[0])
					inc[ch] = weight;
				else
					inc[ch] = {{(`PFC_INC_W - 2){1'b0}}, dec[ch].amt};
			end

			assign clear[ch] = wr_access & pstrb[2] & pwdata[`PFC_CTRL_CLEAR] &
				(word_addr == BASE + `PFC_OFF_CTRL);

			pfc_counter u_cnt (
				.pclk    (pclk),
				.presetn (presetn),
				.clear   (clear[ch]),
				.inc     (inc[ch]),
				.count   (count[ch]),
				.ovf     (ovf[ch])
			);
		end
	endgenerate

	always_comb begin
		logic [`PFC_ADDR_W-1:0] base;
		logic                   hit;
		next_st = st;
		hit     = 1'b0;
		base    = '0;

		// Range tracking: start opens the window, end closes it.
		for (int c = 0; c < `PFC_NUM_CH; c++) begin
			if (!st.ctrl[c].range_en)
				next_st.in_range[c] = 1'b0;
			else if (range_end_hit)
				next_st.in_range[c] = 1'b0;
			else if (range_start_hit)
				next_st.in_range[c] = 1'b1;
		end

		// Register writes take effect at the access-phase edge.
		if (wr_access) begin
			for (int c = 0; c < `PFC_NUM_CH; c++) begin
				base = `PFC_ADDR_W'(`PFC_CH_STRIDE * c);
				if (word_addr == base + `PFC_OFF_CTRL) begin
					if (pstrb[0])
						next_st.ctrl[c].sel = pwdata[`PFC_CTRL_SEL_LSB +: `PFC_SEL_W];
					if (pstrb[1]) begin
						next_st.ctrl[c].method   = pwdata[`PFC_CTRL_METHOD];
						next_st.ctrl[c].range_en = pwdata[`PFC_CTRL_RANGE];
						next_st.ctrl[c].en       = pwdata[`PFC_CTRL_EN];
						// A fresh range setting starts outside the window, unless the
						// start PC is hit in this very cycle: the hardware set wins.
						next_st.in_range[c]      = pwdata[`PFC_CTRL_RANGE] &
							range_start_hit & ~range_end_hit;
					end
				end
			end
		end

		// Read data and error are prepared in the setup cycle so that
		// both come from flip-flops during the zero-wait access phase.
		if (setup) begin
			next_st.rdata  = '0;
			next_st.slverr = 1'b0;
			for (int c = 0; c < `PFC_NUM_CH; c++) begin
				base = `PFC_ADDR_W'(`PFC_CH_STRIDE * c);
				if (word_addr == base + `PFC_OFF_CTRL) begin
					hit = 1'b1;
					if (!pwrite) begin
						next_st.rdata[`PFC_CTRL_SEL_LSB +: `PFC_SEL_W] = st.ctrl[c].sel;
						next_st.rdata[`PFC_CTRL_METHOD] = st.ctrl[c].method;
						next_st.rdata[`PFC_CTRL_RANGE]  = st.ctrl[c].range_en;
						next_st.rdata[`PFC_CTRL_EN]     = st.ctrl[c].en;
					end
				end
				if (word_addr == base + `PFC_OFF_CNT_LO) begin
					hit = 1'b1;
					if (!pwrite) begin
						// Reading the low word freezes the high word, which
						// keeps a 48-bit value coherent across two reads.
						next_st.rdata        = count[c][31:0];
						next_st.hi_shadow[c] = count[c][`PFC_CNT_W-1:32];
					end
				end
				if (word_addr == base + `PFC_OFF_CNT_HI) begin
					hit = 1'b1;
					if (!pwrite) begin
						next_st.rdata[`PFC_HI_W-1:0] = st.hi_shadow[c];
						next_st.rdata[`PFC_HI_OVF]   = ovf[c];
					end
				end
			end
			if (word_addr == `PFC_OFF_STATUS) begin
				hit = 1'b1;
				if (!pwrite) begin
					next_st.rdata[`PFC_ST_RATIO_LSB +: 3] = clk_ratio;
					next_st.rdata[`PFC_ST_OVF_LSB +: `PFC_NUM_CH] = ovf;
					next_st.rdata[`PFC_ST_RANGE_LSB +: `PFC_NUM_CH] = st.in_range;
				end
			end
			// Unmapped words answer zero with an error.
			next_st.slverr = ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	// No wait states are ever needed.
	assign pready  = 1'b1;
	assign prdata  = st.rdata;
	assign pslverr = st.slverr & psel & penable;

endmodule

// File: hw/pfc_defines.svh
// Register map, field positions and weights of the performance counter unit.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

`define PFC_NUM_CH        2
`define PFC_CNT_W         48
`define PFC_HI_W          16
`define PFC_INC_W         5
`define PFC_SEL_W         5
`define PFC_ADDR_W        8

`define PFC_CH_STRIDE     8'h10
`define PFC_OFF_CTRL      8'h00
`define PFC_OFF_CNT_LO    8'h04
`define PFC_OFF_CNT_HI    8'h08
`define PFC_OFF_STATUS    8'h20

`define PFC_CTRL_SEL_LSB  0
`define PFC_CTRL_METHOD   8
`define PFC_CTRL_RANGE    9
`define PFC_CTRL_EN       10
`define PFC_CTRL_CLEAR    16
`define PFC_HI_OVF        31
`define PFC_ST_RATIO_LSB  0
`define PFC_ST_OVF_LSB    4
`define PFC_ST_RANGE_LSB  8

`define PFC_WEIGHT_R0     5'h03
`define PFC_WEIGHT_R1     5'h04
`define PFC_WEIGHT_R2     5'h06
`define PFC_WEIGHT_R3     5'h08
`define PFC_WEIGHT_R4     5'h0C
`define PFC_WEIGHT_R5     5'h18

`endif

// File: hw/pfc_pkg.sv
// Types shared by the performance counter unit.
// Assumes the defines header is on the include path.
`include "pfc_defines.svh"

package pfc_pkg;

	// Event selection codes written into a channel's select field.
	typedef enum logic [4:0] {
		EV_OC_RD     = 5'h00, EV_OC_WR     = 5'h01, EV_OC_RW     = 5'h02,
		EV_IC_MISS   = 5'h03, EV_DATA_TLB  = 5'h04, EV_INST_TLB  = 5'h05,
		EV_CACHED_F  = 5'h06, EV_ALL_F     = 5'h07, EV_BR_ISSUE  = 5'h08,
		EV_BR_TAKEN  = 5'h09, EV_CALL      = 5'h0A, EV_ISSUE     = 5'h0B,
		EV_DUAL      = 5'h0C, EV_FPU       = 5'h0D, EV_TRAP      = 5'h0E,
		EV_INT       = 5'h0F, EV_NMI       = 5'h10, EV_BRK_A     = 5'h11,
		EV_BRK_B     = 5'h12, EV_IC_FILL   = 5'h13, EV_OC_FILL   = 5'h14,
		EV_ELAPSED   = 5'h15, EV_IF_FREEZE = 5'h16, EV_OP_FREEZE = 5'h17,
		EV_BR_FREEZE = 5'h18
	} pfc_evt_e;

	// Per-cycle event indications from the processor core.
	typedef struct packed {
		logic       oc_rd_miss;
		logic       oc_wr_miss;
		logic       ic_miss;
		logic       ic_uncached_slow;
		logic       ic_overrun_miss;
		logic       unified_tlb_data_miss;
		logic       unified_tlb_inst_miss;
		logic       instruction_tlb_miss;
		logic       fetch_accept;
		logic       fetch_cacheable;
		logic       cache_enabled;
		logic       br_issue;
		logic       br_taken;
		logic       br_zero_disp;
		logic       call_issue;
		logic       issue_cycle;
		logic       dual_cycle;
		logic [1:0] fetch_exc_cnt;
		logic [1:0] fpu_slot;
		logic       trap_exec;
		logic       int_accept;
		logic       nmi_accept;
		logic       brk_a_match;
		logic       brk_b_match;
		logic       ic_fill;
		logic       oc_fill;
		logic       if_freeze;
		logic       if_aux_freeze;
		logic       op_freeze;
		logic       op_aux_freeze;
		logic       br_freeze;
		logic       slot_late;
	} pfc_events_t;

	// Decoded contribution of the selected event in one cycle.
	typedef struct packed {
		logic       cyc;
		logic [1:0] amt;
	} pfc_inc_t;

	typedef struct packed {
		logic                     en;
		logic                     range_en;
		logic                     method;
		logic [`PFC_SEL_W-1:0]    sel;
	} pfc_ctrl_t;

	typedef struct packed {
		pfc_ctrl_t [`PFC_NUM_CH-1:0]              ctrl;
		logic [`PFC_NUM_CH-1:0]                   in_range;
		logic [`PFC_NUM_CH-1:0][`PFC_HI_W-1:0]    hi_shadow;
		logic [31:0]                              rdata;
		logic                                     slverr;
	} pfc_state_t;

	typedef struct packed {
		logic [`PFC_CNT_W-1:0]    cnt;
		logic                     ovf;
	} pfc_cnt_state_t;

endpackage

// File: hw/pfc_weight.sv
// Weight of one CPU cycle for ratio-based counting.
// Assumes the ratio code comes straight from the live clock divider setting.
`timescale 1ns/1ps
`include "pfc_defines.svh"

module pfc_weight
	import pfc_pkg::*;
(
	// Clock ratio
	input  wire logic [2:0]              ratio,
	// Weight
	output logic      [`PFC_INC_W-1:0]   weight
);

	// Twenty-four counts make one bus clock period at every ratio.
	always_comb begin
		case (ratio)
			3'h0:    weight = `PFC_WEIGHT_R0;
			3'h1:    weight = `PFC_WEIGHT_R1;
			3'h2:    weight = `PFC_WEIGHT_R2;
			3'h3:    weight = `PFC_WEIGHT_R3;
			3'h4:    weight = `PFC_WEIGHT_R4;
			default: weight = `PFC_WEIGHT_R5;
		endcase
	end

endmodule

// File: hw/pfc_counter.sv
// One 48-bit accumulating counter with sticky overflow.
// Assumes increments of at most 31 per cycle and a one-cycle clear pulse.
`timescale 1ns/1ps
`include "pfc_defines.svh"

module pfc_counter
	import pfc_pkg::*;
(
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// Control
	input  wire logic                    clear,
	input  wire logic [`PFC_INC_W-1:0]   inc,
	// Result
	output logic      [`PFC_CNT_W-1:0]   count,
	output logic                         ovf
);

	pfc_cnt_state_t               st;
	pfc_cnt_state_t               next_st;
	logic [`PFC_CNT_W:0]          sum;

	always_comb begin
		sum     = {1'b0, st.cnt} + {{(`PFC_CNT_W - `PFC_INC_W + 1){1'b0}}, inc};
		next_st = st;
		next_st.cnt = sum[`PFC_CNT_W-1:0];
		if (sum[`PFC_CNT_W])
			next_st.ovf = 1'b1;
		// Clearing restarts the measurement and drops this cycle's increment,
		// but a wrap in that very cycle still marks the result invalid.
		if (clear) begin
			next_st     = '0;
			next_st.ovf = sum[`PFC_CNT_W];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign count = st.cnt;
	assign ovf   = st.ovf;

endmodule

// File: tb/pfc_top_asserts.sv
// Protocol and register-view assertions for the performance counter unit.
// Assumes it is bound to pfc_top and that every watched signal is in the pclk domain.
`timescale 1ns/1ps
`include "pfc_defines.svh"

module pfc_top_asserts
	import pfc_pkg::*;
(
	// Clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// APB
	input wire logic [`PFC_ADDR_W-1:0] paddr,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// Ratio
	input wire logic [2:0]             clk_ratio
);
	logic mapped;

	assign mapped = paddr[7:2] inside {6'h00, 6'h01, 6'h02, 6'h04, 6'h05, 6'h06, 6'h08};

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_rd(logic [5:0] w);
		psel && !penable && !pwrite && paddr[7:2] == w;
	endsequence

	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	a_unmap_err: assert property (s_setup ##0 !mapped |=> pslverr)
		else $error("no error on unmapped word");
	a_map_noerr: assert property (s_setup ##0 mapped |=> !pslverr)
		else $error("error on mapped word");
	a_unmap_zero: assert property (s_setup ##0 !mapped && !pwrite |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
		else $error("read data moved outside setup");
	a_status_ratio: assert property (s_rd(6'h08) |=> prdata[2:0] == $past(clk_ratio))
		else $error("status ratio wrong");
	a_clear_reads0: assert property ((s_rd(6'h00) or s_rd(6'h04)) |=> prdata[31:11] == 21'h0)
		else $error("control upper bits set");
	a_hi_width: assert property ((s_rd(6'h02) or s_rd(6'h06)) |=> prdata[30:16] == 15'h0)
		else $error("high word beyond 48 bits");
endmodule

bind pfc_top pfc_top_asserts i_pfc_top_asserts (
	.pclk      (pclk),
	.presetn   (presetn),
	.paddr     (paddr),
	.psel      (psel),
	.penable   (penable),
	.pwrite    (pwrite),
	.prdata    (prdata),
	.pready    (pready),
	.pslverr   (pslverr),
	.clk_ratio (clk_ratio)
);

// File: tb/pfc_dbg_model.sv
// Debugger model: an APB master that configures and reads the counter unit.
// Assumes the bench calls xfer hierarchically, one transfer at a time.
`timescale 1ns/1ps
`include "pfc_defines.svh"

module pfc_dbg_model
	import pfc_pkg::*;
(
	// Clock
	input wire logic                   pclk,
	// APB master
	output logic [`PFC_ADDR_W-1:0]     paddr,
	output logic                       psel,
	output logic                       penable,
	output logic                       pwrite,
	output logic [31:0]                pwdata,
	output logic [3:0]                 pstrb,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr
);
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end

	// Select, range and clear requests all travel as control writes.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Released lines show garbage so stale values are never trusted.
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// File: tb/pfc_top_tb.sv
// Self-checking bench for the performance counter unit.
// Assumes the debugger model drives APB and the bench drives the core event inputs.
`timescale 1ns/1ps
`include "pfc_defines.svh"

module pfc_top_tb
	import pfc_pkg::*;
;
	logic                   pclk;
	logic                   presetn;
	logic [`PFC_ADDR_W-1:0] paddr;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [31:0]            pwdata;
	logic [3:0]             pstrb;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	pfc_events_t            evt;
	logic [2:0]             clk_ratio;
	logic                   range_start_hit;
	logic                   range_end_hit;
	int                     num_errors = 0;
	int                     check_count = 0;
	int                     wt [6] = '{3, 4, 6, 8, 12, 24};

	pfc_top i_pfc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
		.clk_ratio(clk_ratio), .range_start_hit(range_start_hit),
		.range_end_hit(range_end_hit));

	pfc_dbg_model i_pfc_dbg_model (.pclk(pclk), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end

	task close_out;
		$display("checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task chk(input logic [48:0] got, input logic [48:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// The low word must be read first: it snapshots the high word.
	task automatic rdc(input int ch, output logic [48:0] v);
		logic [31:0] lo;
		logic [31:0] hi;
		logic        e;
		i_pfc_dbg_model.xfer(1'h0, 8'(ch * 16 + 4), 32'h0, lo, e);
		i_pfc_dbg_model.xfer(1'h0, 8'(ch * 16 + 8), 32'h0, hi, e);
		v = {hi[31], hi[15:0], lo};
	endtask

	// Writes select, method and range with the channel enabled and cleared.
	task automatic cfg(input int ch, input logic [4:0] c, input logic m, input logic rg);
		logic [31:0] q;
		logic        e;
		i_pfc_dbg_model.xfer(1'h1, 8'(ch * 16), 32'h10400 | {22'h0, rg, m, 3'h0, c}, q, e);
	endtask

	task automatic pulse(input pfc_events_t e, input int n);
		@(posedge pclk) evt <= e;
		repeat (n) @(posedge pclk);
		evt <= '0;
	endtask

	function automatic pfc_events_t ev(input pfc_evt_e c);
		ev = '0;
		{ev.fetch_cacheable, ev.cache_enabled} = 2'h3;
		case (c)
			EV_OC_RD, EV_OC_RW: ev.oc_rd_miss = 1'h1;
			EV_OC_WR: ev.oc_wr_miss = 1'h1;
			EV_IC_MISS: ev.ic_miss = 1'h1;
			EV_DATA_TLB: ev.unified_tlb_data_miss = 1'h1;
			EV_INST_TLB: ev.instruction_tlb_miss = 1'h1;
			EV_CACHED_F, EV_ALL_F: ev.fetch_accept = 1'h1;
			EV_BR_ISSUE: ev.br_issue = 1'h1;
			EV_BR_TAKEN: {ev.br_issue, ev.br_taken} = 2'h3;
			EV_CALL: ev.call_issue = 1'h1;
			EV_ISSUE: ev.issue_cycle = 1'h1;
			EV_DUAL: {ev.issue_cycle, ev.dual_cycle} = 2'h3;
			EV_FPU: ev.fpu_slot = 2'h1;
			EV_TRAP: ev.trap_exec = 1'h1;
			EV_INT: ev.int_accept = 1'h1;
			EV_NMI: ev.nmi_accept = 1'h1;
			EV_BRK_A: ev.brk_a_match = 1'h1;
			EV_BRK_B: ev.brk_b_match = 1'h1;
			EV_IC_FILL: ev.ic_fill = 1'h1;
			EV_OC_FILL: ev.oc_fill = 1'h1;
			EV_IF_FREEZE: ev.if_freeze = 1'h1;
			EV_OP_FREEZE: ev.op_freeze = 1'h1;
			EV_BR_FREEZE: ev.br_freeze = 1'h1;
			default: ;
		endcase
	endfunction

	// Three event cycles on channel 0 with unit weight.
	task automatic ev_chk(input pfc_evt_e c, input pfc_events_t e, input int per);
		logic [48:0] v;
		cfg(0, c, 1'h0, 1'h0);
		pulse(e, 3);
		rdc(0, v);
		chk(v, 49'(3 * per));
	endtask

	task automatic t_bus;
		logic [31:0] q;
		logic        e;
		i_pfc_dbg_model.xfer(1'h0, 8'h10, 32'h0, q, e);
		chk(49'({e, q}), 49'h0);
		i_pfc_dbg_model.xfer(1'h1, 8'h30, 32'hFFFFFFFF, q, e);
		chk(49'(e), 49'h1);
		i_pfc_dbg_model.xfer(1'h0, 8'h30, 32'h0, q, e);
		chk(49'({e, q}), 49'h100000000);
		clk_ratio <= 3'h5;
		i_pfc_dbg_model.xfer(1'h1, 8'h20, 32'h0, q, e);
		i_pfc_dbg_model.xfer(1'h0, 8'h20, 32'h0, q, e);
		chk(49'({e, q}), 49'h5);
	endtask

	task automatic t_ratio;
		logic [48:0] v;
		pfc_events_t e;
		e = ev(EV_IC_FILL);
		for (int r = 0; r < 6; r++) begin
			clk_ratio <= 3'(r);
			cfg(0, EV_IC_FILL, 1'h0, 1'h0);
			cfg(1, EV_IC_FILL, 1'h1, 1'h0);
			pulse(e, 5);
			rdc(0, v);
			chk(v, 49'h5);
			rdc(1, v);
			chk(v, 49'(5 * wt[r]));
		end
	endtask

	task automatic t_evt;
		pfc_events_t e;
		logic [48:0] v;
		for (int i = 0; i < 25; i++) begin
			if (i != 21) begin
				ev_chk(pfc_evt_e'(i), ev(pfc_evt_e'(i)), 1);
			end
		end
		ev_chk(pfc_evt_e'(5'h19), '1, 0);
		ev_chk(EV_OC_RD, ev(EV_OC_WR), 0);
		ev_chk(EV_OC_RW, ev(EV_OC_WR), 1);
		ev_chk(EV_ISSUE, ev(EV_DUAL), 1);
		ev_chk(EV_DUAL, ev(EV_ISSUE), 0);
		ev_chk(EV_NMI, ev(EV_INT), 0);
		ev_chk(EV_BR_TAKEN, ev(EV_BR_ISSUE), 0);
		e = ev(EV_BR_ISSUE);
		e.br_zero_disp = 1'h1;
		ev_chk(EV_BR_ISSUE, e, 0);
		e = ev(EV_ALL_F);
		e.cache_enabled = 1'h0;
		ev_chk(EV_CACHED_F, e, 0);
		ev_chk(EV_ALL_F, e, 1);
		e = ev(EV_ISSUE);
		e.fetch_exc_cnt = 2'h3;
		ev_chk(EV_ISSUE, e, 3);
		e = '0;
		e.ic_uncached_slow = 1'h1;
		ev_chk(EV_IC_MISS, e, 1);
		e = '0;
		e.op_aux_freeze = 1'h1;
		ev_chk(EV_OP_FREEZE, e, 1);
		e = ev(EV_FPU);
		e.fpu_slot = 2'h3;
		ev_chk(EV_FPU, e, 1);
		e = ev(EV_BR_FREEZE);
		e.slot_late = 1'h1;
		ev_chk(EV_BR_FREEZE, e, 0);
		e = '0;
		e.unified_tlb_inst_miss = 1'h1;
		ev_chk(EV_INST_TLB, e, 1);
		// Elapsed cycles run from the clear edge; the idle cycle before the read counts once.
		cfg(0, EV_ELAPSED, 1'h0, 1'h0);
		rdc(0, v);
		chk(v, 49'h1);
	endtask

	// Fill runs six cycles; only start-hit through end-hit may count.
	task automatic t_range;
		logic [48:0] v;
		cfg(0, EV_IC_FILL, 1'h0, 1'h1);
		@(posedge pclk) evt <= ev(EV_IC_FILL);
		@(posedge pclk) range_start_hit <= 1'h1;
		@(posedge pclk) range_start_hit <= 1'h0;
		@(posedge pclk);
		@(posedge pclk) range_end_hit <= 1'h1;
		@(posedge pclk) range_end_hit <= 1'h0;
		@(posedge pclk) evt <= '0;
		rdc(0, v);
		chk(v, 49'h4);
	endtask

	initial begin
		repeat (6000) @(posedge pclk);
		num_errors++;
		close_out();
	end

	initial begin
		presetn = 1'h0;
		evt = '0;
		clk_ratio = 3'h0;
		range_start_hit = 1'h0;
		range_end_hit = 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_bus();
		t_ratio();
		t_evt();
		t_range();
		close_out();
	end
endmodule
